// ---- logic/pawp_host.sv ----
// host controller end: issues asynchronous strobe-controlled word/byte writes
// assumes the device samples pins on the same clock
`timescale 1ns/1ps
`default_nettype none
module pawp_host (
   input wire logic clock,
   input wire logic nrst,
   pawp_if.host pins,
   input wire logic req_valid,
   input wire logic [pawp_pkg::ADDR_W-1:0] req_addr,
   input wire logic [pawp_pkg::DATA_W-1:0] req_data,
   input wire logic [1:0] req_lanes,
   output logic req_ready
);
   import pawp_pkg::*;
   // ==========================================
   // write sequencer
   pawp_host_state_t st_q, st_d;
   logic [CNT_W-1:0] tmr_q, tmr_d, run_q, run_d;
   logic cs_q, cs_d, we_q, we_d, rdy_q, rdy_d;
   logic [1:0] be_q, be_d;
   logic [ADDR_W-1:0] a_q, a_d;
   logic [DATA_W-1:0] dq_q, dq_d;
   logic [CNT_W-1:0] pulse_len;
   always_comb begin
      st_d = st_q;
      tmr_d = tmr_q;
      run_d = run_q;
      cs_d = cs_q;
      we_d = we_q;
      be_d = be_q;
      a_d = a_q;
      dq_d = dq_q;
      rdy_d = 1'b0;
      // long runs need the stretched pulse; short strobe-high keeps clock ignored
      pulse_len = (run_q >= CNT_W'(BACK_TO_BACK_LIMIT)) ? CNT_W'(WRITE_PULSE_LONG_CYC)
         : CNT_W'(WRITE_PULSE_SHORT_CYC);
      unique case (st_q)
         HST_IDLE: begin
            rdy_d = !req_valid;
            if (req_valid && req_lanes != 2'b00) begin
               a_d = req_addr;
               dq_d = req_data;
               be_d = req_lanes;
               cs_d = 1'b1;
               tmr_d = CNT_W'(SETUP_CYC);
               st_d = HST_SETUP;
            end else if (!req_valid) begin
               run_d = CNT_ZERO;
               cs_d = 1'b0;
            end
         end
         HST_SETUP: begin
            if (tmr_q <= 8'h01) begin
               we_d = 1'b1;
               tmr_d = pulse_len;
               st_d = HST_PULSE;
            end else begin
               tmr_d = tmr_q - 8'h01;
            end
         end
         HST_PULSE: begin
            if (tmr_q <= 8'h01) begin
               we_d = 1'b0;
               tmr_d = CNT_W'(WRITE_HIGH_CYC);
               if (run_q != 8'hFF) begin
                  run_d = run_q + 8'h01;
               end
               st_d = HST_RECOVER;
            end else begin
               tmr_d = tmr_q - 8'h01;
            end
         end
         HST_RECOVER: begin
            // address and data held two cycles past the strobe rise; byte enables drop after one
            be_d = 2'b00;
            rdy_d = 1'b1;
            st_d = HST_IDLE;
         end
      endcase
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         st_q <= HST_IDLE;
         tmr_q <= CNT_ZERO;
         run_q <= CNT_ZERO;
         cs_q <= 1'b0;
         we_q <= 1'b0;
         be_q <= 2'b00;
         a_q <= ADDR_ZERO;
         dq_q <= DATA_ZERO;
         rdy_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tmr_q <= tmr_d;
         run_q <= run_d;
         cs_q <= cs_d;
         we_q <= we_d;
         be_q <= be_d;
         a_q <= a_d;
         dq_q <= dq_d;
         rdy_q <= rdy_d;
      end
   end
   // ==========================================
   // pins; mode pin and output enable held high
   assign pins.chip_select_n = !cs_q;
   assign pins.write_strobe_n = !we_q;
   assign pins.upper_byte_enable_n = !be_q[1];
   assign pins.lower_byte_enable_n = !be_q[0];
   assign pins.output_enable_n = 1'b1;
   assign pins.mode_register_set_pin_n = 1'b1;
   assign pins.address_valid_strobe_n = 1'b1;
   assign pins.burst_clock = 1'b0;
   assign pins.address = a_q;
   assign pins.data_out = dq_q;
   assign pins.data_oe = cs_q;
   assign req_ready = rdy_q;
endmodule
`default_nettype wire

// ---- logic/pawp_pkg.sv ----
// package for the asynchronous write port of a pseudo-static ram
// assumes a single 200 mhz clock shared by both ends
package pawp_pkg;
   // ==========================================
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int DEPTH = 256;
   localparam int CNT_W = 8;
   // ==========================================
   // timing
   localparam int CLK_PERIOD_PS = 5000;
   localparam int WRITE_PULSE_LONG_NS = 70;
   localparam int WRITE_PULSE_LONG_CYC = (WRITE_PULSE_LONG_NS * 1000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int WRITE_PULSE_SHORT_CYC = 2;
   localparam int BACK_TO_BACK_LIMIT = 50;
   localparam int WRITE_HIGH_CYC = 1;
   localparam int SETUP_CYC = 1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
   localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
   typedef enum logic [1:0] {
      HST_IDLE = 2'b00,
      HST_SETUP = 2'b01,
      HST_PULSE = 2'b11,
      HST_RECOVER = 2'b10
   } pawp_host_state_t;
endpackage

// ---- logic/pawp_if.sv ----
// pin bundle between host controller and ram device
// assumes both ends run on one clock; data bus is host driven only
`timescale 1ns/1ps
`default_nettype none
interface pawp_if;
   import pawp_pkg::*;
   logic chip_select_n;
   logic write_strobe_n;
   logic upper_byte_enable_n;
   logic lower_byte_enable_n;
   logic output_enable_n;
   logic mode_register_set_pin_n;
   logic address_valid_strobe_n;
   logic burst_clock;
   logic [ADDR_W-1:0] address;
   logic [DATA_W-1:0] data_out;
   logic data_oe;
   logic wait_out_n;
   logic wait_oe;
   modport host (
      output chip_select_n, write_strobe_n, upper_byte_enable_n, lower_byte_enable_n,
      output output_enable_n, mode_register_set_pin_n, address_valid_strobe_n,
      output burst_clock, address, data_out, data_oe,
      input wait_out_n, wait_oe
   );
   modport device (
      input chip_select_n, write_strobe_n, upper_byte_enable_n, lower_byte_enable_n,
      input output_enable_n, mode_register_set_pin_n, address_valid_strobe_n,
      input burst_clock, address, data_out, data_oe,
      output wait_out_n, wait_oe
   );
endinterface
`default_nettype wire

// ---- logic/pawp_device.sv ----
// ram device end: catches asynchronous writes on the pins into two byte-lane arrays
// assumes pins come from another party and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module pawp_device (
   input wire logic clock,
   input wire logic nrst,
   pawp_if.device pins,
   input wire logic [pawp_pkg::ADDR_W-1:0] peek_addr,
   output logic [pawp_pkg::DATA_W-1:0] peek_data,
   output logic write_done,
   output logic [pawp_pkg::CNT_W-1:0] write_count
);
   import pawp_pkg::*;
   // ==========================================
   // synchronisers: two stages before any logic
   localparam int SW = 4 + ADDR_W + DATA_W;
   logic [SW-1:0] s1_q, s1_d, s2_q, s2_d;
   always_comb begin
      s1_d = {pins.chip_select_n, pins.write_strobe_n, pins.upper_byte_enable_n,
         pins.lower_byte_enable_n, pins.address, pins.data_out};
      s2_d = s1_q;
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         s1_q <= {4'hF, ADDR_ZERO, DATA_ZERO};
         s2_q <= {4'hF, ADDR_ZERO, DATA_ZERO};
      end else begin
         s1_q <= s1_d;
         s2_q <= s2_d;
      end
   end
   logic cs_n, we_n, ub_n, lb_n;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] data;
   assign {cs_n, we_n, ub_n, lb_n, addr, data} = s2_q;
   // burst clock and address strobe are never sampled at all
   // so clock activity cannot disturb a write
   // ==========================================
   // write capture
   logic active_q, active_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] data_q, data_d;
   logic [1:0] lanes_q, lanes_d;
   logic commit;
   logic done_q, done_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [DATA_W-1:0] peek_q;
   always_comb begin
      active_d = !cs_n && !we_n;
      addr_d = addr_q;
      data_d = data_q;
      lanes_d = lanes_q;
      if (active_d) begin
         // latest values seen inside the overlap; data is taken at the end
         addr_d = addr;
         data_d = data;
         lanes_d = {!ub_n, !lb_n};
      end
      commit = active_q && !active_d;
      done_d = commit;
      cnt_d = commit ? cnt_q + 8'h01 : cnt_q;
   end
   always_ff @(posedge clock) begin
      if (!nrst) begin
         active_q <= 1'b0;
         addr_q <= ADDR_ZERO;
         data_q <= DATA_ZERO;
         lanes_q <= 2'b00;
         done_q <= 1'b0;
         cnt_q <= CNT_ZERO;
      end else begin
         active_q <= active_d;
         addr_q <= addr_d;
         data_q <= data_d;
         lanes_q <= lanes_d;
         done_q <= done_d;
         cnt_q <= cnt_d;
      end
   end
   // memory is not reset: contents are undefined after power-up, as in the part
   // one array per byte lane, so each lane is written by a single process
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         logic [7:0] lane_mem [DEPTH];
         always_ff @(posedge clock) begin
            if (commit && lanes_q[g]) begin
               lane_mem[addr_q] <= data_q[g*8 +: 8];
            end
            peek_q[g*8 +: 8] <= lane_mem[peek_addr];
         end
      end
   endgenerate
   // ==========================================
   // outputs; wait is never driven during writes
   assign pins.wait_out_n = 1'b1;
   assign pins.wait_oe = 1'b0;
   assign peek_data = peek_q;
   assign write_done = done_q;
   assign write_count = cnt_q;
endmodule
`default_nettype wire

// ---- testbench/pawp_props.sv ----
// checker on the pins between host and ram device
// assumes one clock and a synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
module pawp_props (
   input wire logic clock,
   input wire logic nrst,
   input wire logic chip_select_n,
   input wire logic write_strobe_n,
   input wire logic upper_byte_enable_n,
   input wire logic lower_byte_enable_n,
   input wire logic output_enable_n,
   input wire logic mode_register_set_pin_n,
   input wire logic [pawp_pkg::ADDR_W-1:0] address,
   input wire logic [pawp_pkg::DATA_W-1:0] data_out,
   input wire logic data_oe,
   input wire logic wait_oe
);
   import pawp_pkg::*;
   // ==========================================
   // write pulse
   default clocking @(posedge clock); endclocking
   default disable iff (!nrst);
   sequence start_s;
      $fell(write_strobe_n);
   endsequence
   sequence pulse_s;
      !write_strobe_n [*2];
   endsequence
   strobe_in_select_a: assert property (!write_strobe_n |-> !chip_select_n)
      else $error("strobe low outside select");
   pulse_min_a: assert property (start_s |-> pulse_s)
      else $error("write pulse too short");
   pulse_end_a: assert property (start_s |-> ##[2:14] write_strobe_n)
      else $error("write pulse never ends");
   lane_set_a: assert property (start_s |-> !(upper_byte_enable_n && lower_byte_enable_n))
      else $error("no lane at write start");
   // held bus avoids a torn word, since the device keeps the last value seen
   bus_hold_a: assert property (!write_strobe_n && !$fell(write_strobe_n)
      |-> $stable(address) && $stable(data_out))
      else $error("bus moved in pulse");
   data_drive_a: assert property (!write_strobe_n |-> data_oe)
      else $error("data not driven");
   pins_high_a: assert property (output_enable_n && mode_register_set_pin_n)
      else $error("mode or output pin low");
   wait_hiz_a: assert property (!wait_oe)
      else $error("wait driven");
endmodule
`default_nettype wire

// ---- testbench/psram_async_write_port_tb.sv ----
// testbench: host and device joined by the pin bundle
// assumes package and interface compiled first
`timescale 1ns/1ps
`default_nettype none
module psram_async_write_port_tb;
   import pawp_pkg::*;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic [ADDR_W-1:0] req_addr = ADDR_ZERO;
   logic [DATA_W-1:0] req_data = DATA_ZERO;
   logic [1:0] req_lanes = 2'b00;
   logic req_ready;
   logic [ADDR_W-1:0] peek_addr = ADDR_ZERO;
   logic [DATA_W-1:0] peek_data;
   logic [CNT_W-1:0] write_count;
   logic write_done;
   logic [CNT_W-1:0] done_q = CNT_ZERO;
   logic [CNT_W-1:0] exp_cnt = CNT_ZERO;
   logic [CNT_W-1:0] lo_q = CNT_ZERO;
   logic [CNT_W-1:0] last_q = CNT_ZERO;
   int fail_count = 0;
   int samples_checked = 0;
   pawp_if bus ();
   pawp_host u_pawp_host (.clock(clock), .nrst(nrst), .pins(bus), .req_valid(req_valid),
      .req_addr(req_addr), .req_data(req_data), .req_lanes(req_lanes), .req_ready(req_ready));
   pawp_device u_pawp_device (.clock(clock), .nrst(nrst), .pins(bus), .peek_addr(peek_addr),
      .peek_data(peek_data), .write_done(write_done), .write_count(write_count));
   pawp_props u_pawp_props (.clock(clock), .nrst(nrst), .chip_select_n(bus.chip_select_n),
      .write_strobe_n(bus.write_strobe_n), .upper_byte_enable_n(bus.upper_byte_enable_n),
      .lower_byte_enable_n(bus.lower_byte_enable_n), .output_enable_n(bus.output_enable_n),
      .mode_register_set_pin_n(bus.mode_register_set_pin_n), .address(bus.address),
      .data_out(bus.data_out), .data_oe(bus.data_oe), .wait_oe(bus.wait_oe));
   initial begin
      forever #2.5 clock = ~clock;
   end
   // ==========================================
   // length of the last strobe pulse seen on the pins
   always @(posedge clock) begin
      if (!bus.write_strobe_n) begin
         lo_q <= lo_q + 8'h01;
      end else if (lo_q != CNT_ZERO) begin
         last_q <= lo_q;
         lo_q <= CNT_ZERO;
      end
   end
   // one done pulse per committed write
   always @(posedge clock) begin
      if (write_done) begin
         done_q <= done_q + 8'h01;
      end
   end
   task automatic finish_test;
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   // leaves the request up so a burst runs back to back
   task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] l);
      int n;
      n = 0;
      req_valid = 1'b1;
      req_addr = a;
      req_data = d;
      req_lanes = l;
      exp_cnt = exp_cnt + 8'h01;
      do begin
         @(negedge clock);
         n++;
      end while (req_ready !== 1'b1 && n < 40);
      check(16'(req_ready), 16'h0001);
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      req_valid = 1'b0;
      @(negedge clock);
      peek_addr = a;
      repeat (3) @(negedge clock);
      check(peek_data, exp);
   endtask
   initial begin
      #100000;
      fail_count++;
      finish_test;
   end
   initial begin
      repeat (2) @(negedge clock);
      nrst = 1'b1;
      wr(8'h10, 16'hA5C3, 2'b11);
      check(16'(last_q), 16'(WRITE_PULSE_SHORT_CYC));
      rd(8'h10, 16'hA5C3);
      wr(8'h10, 16'h1234, 2'b10);
      rd(8'h10, 16'h12C3);
      wr(8'h10, 16'h5678, 2'b01);
      rd(8'h10, 16'h1278);
      $display("lane tests done");
      req_lanes = 2'b00;
      req_valid = 1'b1;
      repeat (10) @(negedge clock);
      check(16'(write_count), 16'(exp_cnt));
      check(16'(done_q), 16'(exp_cnt));
      for (int i = 0; i < 52; i++) begin
         wr(8'(i), {8'(i), ~8'(i)}, 2'b11);
      end
      check(16'(last_q), 16'(WRITE_PULSE_LONG_CYC));
      rd(8'h33, 16'h33CC);
      check(16'(write_count), 16'(exp_cnt));
      check(16'(done_q), 16'(exp_cnt));
      $display("burst test done");
      finish_test;
   end
endmodule
`default_nettype wire
